// [wrt_device.sv]
// Watchdog reset timer: counter, control registers and chip reset
// Operation
// RULE1: 8-bit counter steps on each selected tick
// RULE2: Select code picks clock/64 up to clock/8192
// RULE3: Select upper bits read ones; reset all ones
// RULE4: Wrap from max raises reset and flag
// RULE5: Reset starts one cycle after wrapping tick; the code starts it two cycles after, through overflow_r
// RULE6: Reset lasts 512 oscillator cycles
// RULE7: Enable bit written only with inhibit zero
// RULE8: Counter runs only while enabled
// RULE9: Status write enable guarded by bit five
// RULE10: Counter write enable guarded by bit seven
// RULE11: Inhibit bits read one, store nothing
// RULE12: Flag cleared by pin or guarded zero write
// RULE13: Written count is the new start point
// RULE14: Reset gives count zero, control alternating
// RULE15: Overflow reset drives the whole chip
// RULE16: Variant without watchdog reads ones, ignores writes
// RULE17: Flag survives the watchdog's own reset
//
// The APB interface to the registers was left to the implementer.
module wrt_device #(
	parameter bit HAS_WATCHDOG = 1'b1
) (
	// Clock and external reset pin
	input wire logic clock,
	input wire logic reset,
	// Register port
	wrt_bus_if.dev bus,
	// User side
	output logic internal_reset,
	output logic watchdog_reset_flag
);
	import wrt_pkg::*;

	logic counter_write_enable_r;
	logic status_write_enable_r;
	logic watchdog_on_r;
	logic flag_r;
	logic [7:0] count_r;
	logic [2:0] clksel_r;
	logic overflow_r;
	logic chip_reset_r;
	logic [RST_CNT_W-1:0] rst_cnt_r;
	logic ack_r;
	logic [7:0] rdata_r;
	logic tick;
	logic write;
	logic wr_ctrl;
	logic wr_count;
	logic wr_clksel;
	logic step;
	logic wrap;
	logic [7:0] ctrl_view;

	// ==========================================
	// Decode
	// Writes during the chip reset are dropped, reads are still answered; the CPU is held anyway
	assign write = bus.req && bus.wr && HAS_WATCHDOG && !chip_reset_r; // [RULE16]
	assign wr_ctrl = write && (bus.addr == ADDR_CTRL);
	assign wr_count = write && (bus.addr == ADDR_COUNT);
	assign wr_clksel = write && (bus.addr == ADDR_CLKSEL);

	// ==========================================
	// Prescaler
	wrt_prescaler #(
		.BASE_LOG2(PRE_BASE_LOG2),
		.TAPS(PRE_TAPS)
	) wrt_prescaler_inst (
		.clock(clock),
		.reset(reset),
		.clear(chip_reset_r),
		.sel(clksel_r),
		.tick(tick)
	);

	assign step = tick && watchdog_on_r && !chip_reset_r; // [RULE8]
	// A load in the same cycle wins and cancels the wrap
	// A refused load must not swallow the wrap
	assign wrap = step && !(wr_count && counter_write_enable_r)
		&& (count_r == COUNT_MAX); // [RULE4]

	// ==========================================
	// Control bits
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			counter_write_enable_r <= CTRL_RESET[BIT_CWE]; // [RULE14]
		end else if (chip_reset_r) begin
			counter_write_enable_r <= CTRL_RESET[BIT_CWE]; // [RULE15]
		end else if (wr_ctrl && !bus.wdata[BIT_CWE_INH]) begin
			counter_write_enable_r <= bus.wdata[BIT_CWE]; // [RULE10]
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			status_write_enable_r <= CTRL_RESET[BIT_SWE];
		end else if (chip_reset_r) begin
			status_write_enable_r <= CTRL_RESET[BIT_SWE];
		end else if (wr_ctrl && !bus.wdata[BIT_SWE_INH]) begin
			status_write_enable_r <= bus.wdata[BIT_SWE]; // [RULE9]
		end
	end

	// Guard uses the enable as it stood before this write
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			watchdog_on_r <= CTRL_RESET[BIT_ON];
		end else if (chip_reset_r) begin
			watchdog_on_r <= CTRL_RESET[BIT_ON];
		end else if (wr_ctrl && !bus.wdata[BIT_ON_INH] && status_write_enable_r) begin
			watchdog_on_r <= bus.wdata[BIT_ON]; // [RULE7]
		end
	end

	// Only the pin or a guarded zero write clears it, so software can see why it restarted
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			flag_r <= CTRL_RESET[BIT_FLAG]; // [RULE12]
		end else if (wrap) begin
			flag_r <= 1'b1; // [RULE4] [RULE17]
		end else if (wr_ctrl && !bus.wdata[BIT_FLAG_INH] && status_write_enable_r
			&& !bus.wdata[BIT_FLAG]) begin
			flag_r <= 1'b0; // [RULE12]
		end
	end

	// ==========================================
	// Counter and clock select
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			count_r <= COUNT_RESET; // [RULE14]
		end else if (chip_reset_r) begin
			count_r <= COUNT_RESET;
		end else if (wr_count && counter_write_enable_r) begin
			count_r <= bus.wdata; // [RULE13]
		end else if (step) begin
			count_r <= count_r + 8'h01; // [RULE1]
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			clksel_r <= CLKSEL_RESET; // [RULE3]
		end else if (chip_reset_r) begin
			clksel_r <= CLKSEL_RESET;
		end else if (wr_clksel) begin
			clksel_r <= bus.wdata[2:0]; // [RULE2]
		end
	end

	// ==========================================
	// Internal chip reset
	always_ff @(posedge clock or posedge reset) begin
		if (reset)
			overflow_r <= 1'b0;
		else
			overflow_r <= wrap; // [RULE5]
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			chip_reset_r <= 1'b0;
			rst_cnt_r <= RST_ZERO;
		end else if (overflow_r) begin
			chip_reset_r <= 1'b1; // [RULE5]
			rst_cnt_r <= RST_LOAD; // [RULE6]
		end else if (chip_reset_r) begin
			if (rst_cnt_r == RST_ZERO)
				chip_reset_r <= 1'b0; // [RULE6]
			else
				rst_cnt_r <= rst_cnt_r - 1'b1;
		end
	end

	// ==========================================
	// Read back
	always_comb begin
		ctrl_view = BYTE_ONES; // [RULE11]
		ctrl_view[BIT_CWE] = counter_write_enable_r;
		ctrl_view[BIT_SWE] = status_write_enable_r;
		ctrl_view[BIT_ON] = watchdog_on_r;
		ctrl_view[BIT_FLAG] = flag_r;
	end

	// Other addresses belong to other blocks and read zero here
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			rdata_r <= BYTE_ZERO;
		end else if (bus.req) begin
			if (!HAS_WATCHDOG && (bus.addr == ADDR_CTRL || bus.addr == ADDR_COUNT
				|| bus.addr == ADDR_CLKSEL))
				rdata_r <= BYTE_ONES; // [RULE16]
			else if (bus.addr == ADDR_CTRL)
				rdata_r <= ctrl_view;
			else if (bus.addr == ADDR_COUNT)
				rdata_r <= count_r;
			else if (bus.addr == ADDR_CLKSEL)
				rdata_r <= {CLKSEL_ONES, clksel_r}; // [RULE3]
			else
				rdata_r <= BYTE_ZERO;
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset)
			ack_r <= 1'b0;
		else
			ack_r <= bus.req;
	end

	assign bus.rdata = rdata_r;
	assign bus.ack = ack_r;
	assign bus.chip_reset = chip_reset_r; // [RULE15]
	assign internal_reset = chip_reset_r;
	assign watchdog_reset_flag = flag_r;
endmodule

// [wrt_pkg.sv]
// Shared constants for the watchdog reset timer and its controller
package wrt_pkg;
	// ==========================================
	// Device register addresses and layout
	localparam logic [15:0] ADDR_CTRL = 16'hff90;
	localparam logic [15:0] ADDR_COUNT = 16'hff91;
	localparam logic [15:0] ADDR_CLKSEL = 16'hff92;
	localparam logic [7:0] CTRL_RESET = 8'haa;
	localparam logic [7:0] COUNT_RESET = 8'h00;
	localparam logic [7:0] COUNT_MAX = 8'hff;
	localparam logic [2:0] CLKSEL_RESET = 3'h7;
	localparam logic [4:0] CLKSEL_ONES = 5'h1f;
	localparam logic [7:0] BYTE_ONES = 8'hff;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam int BIT_CWE_INH = 7;
	localparam int BIT_CWE = 6;
	localparam int BIT_SWE_INH = 5;
	localparam int BIT_SWE = 4;
	localparam int BIT_ON_INH = 3;
	localparam int BIT_ON = 2;
	localparam int BIT_FLAG_INH = 1;
	localparam int BIT_FLAG = 0;
	// ==========================================
	// Prescaler: codes 0..7 give clock/64 .. clock/8192
	localparam int PRE_BASE_LOG2 = 6;
	localparam int PRE_TAPS = 8;
	// ==========================================
	// Timing
	localparam int SYS_CLK_MHZ = 100;
	localparam int OSC_CLK_MHZ = 100;
	localparam int RST_OSC_CYCLES = 512;
	localparam int RST_SYS_CYCLES =
		(RST_OSC_CYCLES * SYS_CLK_MHZ + OSC_CLK_MHZ - 1) / OSC_CLK_MHZ;
	localparam int RST_CNT_W = $clog2(RST_SYS_CYCLES + 1);
	localparam logic [RST_CNT_W-1:0] RST_LOAD = RST_CNT_W'(RST_SYS_CYCLES - 1);
	localparam logic [RST_CNT_W-1:0] RST_ZERO = '0;
	// ==========================================
	// Controller APB map
	localparam logic [7:0] APB_CMD = 8'h00;
	localparam logic [7:0] APB_STATUS = 8'h04;
	localparam logic [7:0] APB_IRQ_STAT = 8'h08;
	localparam logic [7:0] APB_IRQ_MASK = 8'h0c;
	localparam int CMD_WR_BIT = 24;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_WDRST = 1;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
	typedef enum logic [1:0] {
		WRT_IDLE = 2'b00,
		WRT_REQ = 2'b01,
		WRT_WAIT = 2'b10
	} wrt_host_state_t;
endpackage

// [wrt_bus_if.sv]
// Byte register port between the controller and the watchdog
interface wrt_bus_if;
	logic req;
	logic wr;
	logic [15:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic ack;
	logic chip_reset;
	modport host (output req, output wr, output addr, output wdata,
		input rdata, input ack, input chip_reset);
	modport dev (input req, input wr, input addr, input wdata,
		output rdata, output ack, output chip_reset);
endinterface

// [wrt_prescaler.sv]
// Clock divider giving one-cycle ticks at a selectable rate
module wrt_prescaler #(
	parameter int BASE_LOG2 = wrt_pkg::PRE_BASE_LOG2,
	parameter int TAPS = wrt_pkg::PRE_TAPS
) (
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	input wire logic clear,
	// Rate select and tick
	input wire logic [$clog2(TAPS)-1:0] sel,
	output logic tick
);
	import wrt_pkg::*;
	localparam int DIV_W = BASE_LOG2 + TAPS - 1;
	logic [DIV_W-1:0] div_r;
	logic [TAPS-1:0] taps;

	// Select code must index every tap and no more
	if (BASE_LOG2 < 1 || TAPS < 2 || TAPS != (1 << $clog2(TAPS)))
		$error("wrt_prescaler: unsupported divider shape");

	always_ff @(posedge clock or posedge reset) begin
		if (reset)
			div_r <= '0;
		else if (clear)
			div_r <= '0;
		else
			div_r <= div_r + 1'b1;
	end

	// One tick per 2^(BASE_LOG2+i) clocks
	for (genvar i = 0; i < TAPS; i++) begin : g_tap
		assign taps[i] = &div_r[BASE_LOG2+i-1:0]; // [RULE2]
	end

	assign tick = taps[sel];
endmodule

// [wrt_host.sv]
// Controller: APB command registers driving the watchdog register port
module wrt_host (
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Interrupt
	output logic irq,
	// Watchdog port
	wrt_bus_if.host bus
);
	import wrt_pkg::*;

	wrt_host_state_t state_r;
	logic [31:0] prdata_r;
	logic pready_r;
	logic pslverr_r;
	logic irq_r;
	logic [1:0] irq_stat_r;
	logic [1:0] irq_mask_r;
	logic [7:0] rd_byte_r;
	logic req_r;
	logic wr_r;
	logic [15:0] addr_r;
	logic [7:0] wdata_r;
	logic rst_seen_r;
	logic access;
	logic done;
	logic mapped;
	logic start;
	logic [1:0] irq_set;
	logic [1:0] irq_stat_nxt;

	// ==========================================
	// APB: one wait state so read data comes from a flop
	assign access = psel && penable && !pready_r;
	assign done = psel && penable && pready_r;
	assign mapped = paddr == APB_CMD || paddr == APB_STATUS
		|| paddr == APB_IRQ_STAT || paddr == APB_IRQ_MASK;
	assign start = done && pwrite && paddr == APB_CMD && state_r == WRT_IDLE;

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= WORD_ZERO;
		end else begin
			pready_r <= access;
			pslverr_r <= access && !mapped;
			if (access && !pwrite) begin
				unique case (paddr)
					APB_STATUS: prdata_r <= {22'h00_0000, bus.chip_reset,
						state_r != WRT_IDLE, rd_byte_r};
					APB_IRQ_STAT: prdata_r <= {30'h0000_0000, irq_stat_r};
					APB_IRQ_MASK: prdata_r <= {30'h0000_0000, irq_mask_r};
					default: prdata_r <= WORD_ZERO;
				endcase
			end
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset)
			irq_mask_r <= 2'h0;
		else if (done && pwrite && paddr == APB_IRQ_MASK)
			irq_mask_r <= pwdata[1:0];
	end

	// ==========================================
	// Sticky events; a new event beats the read clear
	always_ff @(posedge clock or posedge reset) begin
		if (reset)
			rst_seen_r <= 1'b0;
		else
			rst_seen_r <= bus.chip_reset;
	end

	always_comb begin
		irq_set = 2'h0;
		irq_set[IRQ_DONE] = state_r == WRT_WAIT && bus.ack;
		irq_set[IRQ_WDRST] = bus.chip_reset && !rst_seen_r;
		irq_stat_nxt = irq_stat_r;
		if (done && !pwrite && paddr == APB_IRQ_STAT)
			irq_stat_nxt = 2'h0;
		irq_stat_nxt = irq_stat_nxt | irq_set;
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			irq_stat_r <= 2'h0;
			irq_r <= 1'b0;
		end else begin
			irq_stat_r <= irq_stat_nxt;
			irq_r <= |(irq_stat_nxt & irq_mask_r);
		end
	end

	// ==========================================
	// Register port sequencer
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			state_r <= WRT_IDLE;
			req_r <= 1'b0;
			wr_r <= 1'b0;
			addr_r <= 16'h0000;
			wdata_r <= BYTE_ZERO;
			rd_byte_r <= BYTE_ZERO;
		end else begin
			unique case (state_r)
				WRT_IDLE: if (start) begin
					req_r <= 1'b1;
					wr_r <= pwdata[CMD_WR_BIT];
					addr_r <= pwdata[23:8];
					wdata_r <= pwdata[7:0];
					state_r <= WRT_REQ;
				end
				WRT_REQ: begin
					req_r <= 1'b0;
					state_r <= WRT_WAIT;
				end
				WRT_WAIT: if (bus.ack) begin
					rd_byte_r <= bus.rdata;
					state_r <= WRT_IDLE;
				end
				default: state_r <= WRT_IDLE;
			endcase
		end
	end

	assign bus.req = req_r;
	assign bus.wr = wr_r;
	assign bus.addr = addr_r;
	assign bus.wdata = wdata_r;
	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign irq = irq_r;
endmodule

// [wrt_bus_monitor.sv]
// Checks on the register port between controller and watchdog
module wrt_bus_monitor (
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	// Register port
	input wire logic req,
	input wire logic wr,
	input wire logic [15:0] addr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata,
	input wire logic ack,
	input wire logic chip_reset
);
	timeunit 1ns;
	timeprecision 100ps;
	import wrt_pkg::*;

	// ========
	// Chip reset length
	logic [9:0] hold_r;
	always_ff @(posedge clock or posedge reset) begin
		if (reset)
			hold_r <= '0;
		else if (chip_reset)
			hold_r <= hold_r + 10'h001;
		else
			hold_r <= '0;
	end

	default clocking @(posedge clock); endclocking
	default disable iff (reset);

	// ========
	// Assertions
	ack_follows_req_a: assert property (req |=> ack ##1 !ack)
		else $error("ack not one cycle after req");
	ack_has_cause_a: assert property (ack |-> $past(req))
		else $error("ack without req");
	request_stable_a: assert property (req |=> $stable(addr) && $stable(wdata))
		else $error("address or data moved under req");
	inhibit_reads_one_a: assert property (ack && !$past(wr) && $past(addr) == ADDR_CTRL
		|-> (rdata & CTRL_RESET) == CTRL_RESET) else $error("inhibit bit read zero");
	select_upper_ones_a: assert property (ack && !$past(wr) && $past(addr) == ADDR_CLKSEL
		|-> rdata[7:3] == CLKSEL_ONES) else $error("select upper bits not ones");
	reset_length_a: assert property ($fell(chip_reset) |-> hold_r == RST_SYS_CYCLES)
		else $error("chip reset wrong length");
	reset_bounded_a: assert property (chip_reset |-> hold_r < RST_SYS_CYCLES)
		else $error("chip reset too long");
	chip_clears_ctrl_a: assert property (ack && !$past(wr) && $past(addr) == ADDR_CTRL
		&& $past(chip_reset, 2) && $past(chip_reset) |-> rdata == 8'hab)
		else $error("control wrong during chip reset");
	chip_clears_count_a: assert property (ack && !$past(wr) && $past(addr) == ADDR_COUNT
		&& $past(chip_reset, 2) && $past(chip_reset) |-> rdata == COUNT_RESET)
		else $error("counter not cleared by chip reset");

	cover property ($fell(chip_reset));
	cover property (ack && $past(wr) && $past(addr) == ADDR_COUNT);
	cover property (ack && $past(chip_reset));
endmodule

// [watchdog_reset_timer_tb.sv]
// Testbench joining controller and watchdog over the register port
module watchdog_reset_timer_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import wrt_pkg::*;

	logic clock, reset, psel, penable, pwrite, pready, pslverr, irq, wd_flag, rd_err;
	logic wd_rst, bare_rst;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd_q, prdata_bare, rd_q2;
	int bad_count, cmp_count, k, n;

	wrt_bus_if wrt_bus_if_inst ();
	wrt_host wrt_host_inst (.clock(clock), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .bus(wrt_bus_if_inst));
	wrt_device wrt_device_inst (.clock(clock), .reset(reset), .bus(wrt_bus_if_inst),
		.internal_reset(wd_rst), .watchdog_reset_flag(wd_flag));
	// ==========================================
	// Variant without the watchdog, driven in step with the main pair
	wrt_bus_if bare_bus_if_inst ();
	wrt_host wrt_host_bare_inst (.clock(clock), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata_bare), .pready(),
		.pslverr(), .irq(), .bus(bare_bus_if_inst));
	wrt_device #(.HAS_WATCHDOG(1'b0)) wrt_device_bare_inst (.clock(clock), .reset(reset),
		.bus(bare_bus_if_inst), .internal_reset(bare_rst), .watchdog_reset_flag());
	wrt_bus_monitor wrt_bus_monitor_inst (.clock(clock), .reset(reset),
		.req(wrt_bus_if_inst.req), .wr(wrt_bus_if_inst.wr), .addr(wrt_bus_if_inst.addr),
		.wdata(wrt_bus_if_inst.wdata), .rdata(wrt_bus_if_inst.rdata),
		.ack(wrt_bus_if_inst.ack), .chip_reset(wrt_bus_if_inst.chip_reset));

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// ========
	// Report and compare
	task automatic results;
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic wait_out;
		bad_count++;
		$display("mismatch at %0t: wait limit", $time);
		results();
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic chk_in(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
		cmp_count++;
		if ((got >= lo && got <= hi) !== 1'b1) begin
			bad_count++;
			$display("mismatch at %0t: %0d out of range", $time, got);
		end
	endtask

	// ========
	// Bus access
	// Idle cycle after each transfer keeps drivers from two writes in one step
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge clock);
			i++;
		end while (pready !== 1'b1 && i < 20);
		rd_q = prdata;
		rd_q2 = prdata_bare;
		rd_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1)
			wait_out();
		@(posedge clock);
	endtask
	task automatic dev(input logic w, input logic [15:0] a, input logic [7:0] d);
		int i;
		apb(1'b1, APB_CMD, {7'h00, w, a, d});
		i = 0;
		do begin
			apb(1'b0, APB_STATUS, WORD_ZERO);
			i++;
		end while (rd_q[8] !== 1'b0 && i < 20);
		if (rd_q[8] !== 1'b0)
			wait_out();
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] exp);
		dev(1'b0, a, BYTE_ZERO);
		chk(rd_q[7:0], exp);
		chk(rd_q2[7:0], BYTE_ONES);
	endtask

	// ========
	// Sequence
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = WORD_ZERO;
		reset = 1'b1;
		bad_count = 0;
		cmp_count = 0;
		repeat (5) @(posedge clock);
		reset <= 1'b0;
		@(posedge clock);
		rd(ADDR_CTRL, CTRL_RESET);
		rd(ADDR_COUNT, COUNT_RESET);
		rd(ADDR_CLKSEL, BYTE_ONES);
		apb(1'b1, APB_IRQ_MASK, 32'h0000_0002);
		apb(1'b0, APB_IRQ_MASK, WORD_ZERO);
		chk(rd_q[7:0], 8'h02);
		apb(1'b0, 8'h10, WORD_ZERO);
		chk({7'h00, rd_err}, 8'h01);
		dev(1'b1, ADDR_CTRL, 8'hbe);
		rd(ADDR_CTRL, CTRL_RESET);
		dev(1'b1, ADDR_CTRL, 8'h04);
		rd(ADDR_CTRL, CTRL_RESET);
		dev(1'b1, ADDR_CTRL, 8'h10);
		rd(ADDR_CTRL, 8'hba);
		dev(1'b1, ADDR_CLKSEL, BYTE_ZERO);
		rd(ADDR_CLKSEL, 8'hf8);
		dev(1'b1, ADDR_COUNT, 8'h33);
		rd(ADDR_COUNT, COUNT_RESET);
		repeat (200) @(posedge clock);
		rd(ADDR_COUNT, COUNT_RESET);
		dev(1'b1, ADDR_CTRL, 8'h54);
		rd(ADDR_CTRL, 8'hfe);
		// Prescaler runs free, so three periods hold three or four ticks
		for (k = 0; k < 8; k++) begin
			dev(1'b1, ADDR_CLKSEL, 8'(k));
			dev(1'b1, ADDR_COUNT, COUNT_RESET);
			repeat (3 << (6 + k)) @(posedge clock);
			dev(1'b0, ADDR_COUNT, BYTE_ZERO);
			chk_in({8'h00, rd_q[7:0]}, 16'h0003, 16'h0004);
		end
		dev(1'b1, ADDR_CLKSEL, BYTE_ZERO);
		dev(1'b1, ADDR_COUNT, 8'hfd);
		n = 0;
		while (wrt_bus_if_inst.chip_reset !== 1'b1 && n < 400) begin
			@(posedge clock);
			n++;
		end
		if (wrt_bus_if_inst.chip_reset !== 1'b1)
			wait_out();
		chk_in(16'(n), 16'h0078, 16'h00c8);
		chk({7'h00, wd_rst}, 8'h01);
		rd(ADDR_CTRL, 8'hab);
		rd(ADDR_COUNT, COUNT_RESET);
		chk({7'h00, irq}, 8'h01);
		apb(1'b0, APB_IRQ_STAT, WORD_ZERO);
		chk({7'h00, rd_q[1]}, 8'h01);
		apb(1'b0, APB_IRQ_STAT, WORD_ZERO);
		chk({7'h00, rd_q[1] | irq}, 8'h00);
		n = 0;
		while (wrt_bus_if_inst.chip_reset !== 1'b0 && n < 600) begin
			@(posedge clock);
			n++;
		end
		if (wrt_bus_if_inst.chip_reset !== 1'b0)
			wait_out();
		chk({7'h00, wd_rst}, 8'h00);
		rd(ADDR_CTRL, 8'hab);
		rd(ADDR_CLKSEL, BYTE_ONES);
		chk({7'h00, wd_flag}, 8'h01);
		dev(1'b1, ADDR_CTRL, 8'h10);
		rd(ADDR_CTRL, 8'hbb);
		dev(1'b1, ADDR_CTRL, 8'h10);
		rd(ADDR_CTRL, 8'hba);
		chk({7'h00, wd_flag}, 8'h00);
		chk({7'h00, bare_rst}, 8'h00);
		results();
	end
endmodule
